// >>> design/fast_source_stable_flag_osc_block.sv
// Local design decisions: the strobed register port and the address map.
`timescale 1ns/1ps
module fast_source_stable_flag_osc_block
  import fast_source_stable_flag_pkg::*;
#(
  parameter int STAB_CYCLES = FAST_SOURCE_STABLE_FLAG_STAB_CYCLES,
  parameter int DIV_WIDTH   = 6
) (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  // Oscillator ticks: one pulse per source period, from analog cells
  input  wire logic       fast_tick,
  input  wire logic       slow_tick,
  // Register port
  input  wire logic [1:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_write,
  input  wire logic       reg_read,
  output logic      [7:0] reg_rdata,
  // Analog trim, signed offset
  output logic      [5:0] trim_value,
  // Oscillator enables
  output logic            fast_osc_enable,
  output logic            slow_osc_enable,
  // Clock result
  output logic            clock_output,
  output logic            switch_busy,
  // Oscillator pins (two-way)
  input  wire logic       first_osc_pin_in,
  output logic            first_osc_pin_out,
  output logic            first_osc_pin_oe,
  input  wire logic       second_osc_pin_in,
  output logic            second_osc_pin_out,
  output logic            second_osc_pin_oe,
  // Port bit 6/7 to the port logic
  input  wire logic       port_bit_six_out,
  input  wire logic       port_bit_six_oe,
  output logic            port_bit_six_in,
  input  wire logic       port_bit_seven_out,
  input  wire logic       port_bit_seven_oe,
  output logic            port_bit_seven_in
);
  import fast_source_stable_flag_pkg::*;

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [5:0] trim_q, trim_d;
  logic [2:0] freq_select_q, freq_select_d;
  logic [2:0] pinmode_q, pinmode_d;
  logic [7:0] rdata_q, rdata_d;
  logic [2:0] active_sel_q, active_sel_d;
  logic       stable_q, stable_d;

  function automatic logic sel_is_slow(input logic [2:0] sel);
    return sel == FAST_SOURCE_STABLE_FLAG_SEL_SLOW;
  endfunction

  always_comb begin
    trim_d        = trim_q;
    freq_select_d = freq_select_q;
    pinmode_d     = pinmode_q;
    rdata_d       = '0;
    if (reg_write) begin
      unique case (reg_addr)
        FAST_SOURCE_STABLE_FLAG_ADDR_TRIM: begin
          trim_d = reg_wdata[FAST_SOURCE_STABLE_FLAG_TRIM_MSB:0];
        end
        FAST_SOURCE_STABLE_FLAG_ADDR_CONTROL: begin
          freq_select_d = reg_wdata[FAST_SOURCE_STABLE_FLAG_SEL_MSB:FAST_SOURCE_STABLE_FLAG_SEL_LSB];
        end
        FAST_SOURCE_STABLE_FLAG_ADDR_PINMODE: begin
          pinmode_d = reg_wdata[FAST_SOURCE_STABLE_FLAG_PM_PWT_BIT:FAST_SOURCE_STABLE_FLAG_PM_IO_BIT];
        end
        FAST_SOURCE_STABLE_FLAG_ADDR_STATUS: begin
          pinmode_d = pinmode_q;
        end
      endcase
    end
    if (reg_read) begin
      unique case (reg_addr)
        FAST_SOURCE_STABLE_FLAG_ADDR_TRIM: begin
          rdata_d[FAST_SOURCE_STABLE_FLAG_TRIM_MSB:0] = trim_q;
        end
        FAST_SOURCE_STABLE_FLAG_ADDR_CONTROL: begin
          rdata_d[FAST_SOURCE_STABLE_FLAG_SEL_MSB:FAST_SOURCE_STABLE_FLAG_SEL_LSB] = freq_select_q;
          rdata_d[FAST_SOURCE_STABLE_FLAG_STABLE_BIT] = stable_q;
        end
        FAST_SOURCE_STABLE_FLAG_ADDR_PINMODE: begin
          rdata_d[FAST_SOURCE_STABLE_FLAG_PM_PWT_BIT:FAST_SOURCE_STABLE_FLAG_PM_IO_BIT] = pinmode_q;
        end
        FAST_SOURCE_STABLE_FLAG_ADDR_STATUS: begin
          rdata_d[FAST_SOURCE_STABLE_FLAG_SEL_MSB:FAST_SOURCE_STABLE_FLAG_SEL_LSB] = active_sel_q;
          rdata_d[0] = switch_busy;
        end
      endcase
    end
  end

  // ****************************************************************
  // Sources and divider
  // ****************************************************************
  // Ticks come from free-running cells, hence the double register
  logic [1:0] fast_sync_q, slow_sync_q;
  logic       fast_prev_q, slow_prev_q;
  logic       fast_edge, slow_edge;
  logic [DIV_WIDTH-1:0] taps;

  assign fast_edge = fast_sync_q[1] & ~fast_prev_q;
  assign slow_edge = slow_sync_q[1] & ~slow_prev_q;

  // Tick per fast period: tap k toggles every 2^k periods
  fast_source_stable_flag_clk_div #(.WIDTH(DIV_WIDTH)) u_div (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .tick     (fast_edge),
    .taps     (taps)
  );

  // Level of a candidate clock for a given select code
  function automatic logic src_level(input logic [2:0] sel,
                                     input logic [DIV_WIDTH-1:0] t,
                                     input logic fl, input logic sl);
    if (sel == FAST_SOURCE_STABLE_FLAG_SEL_SLOW) begin
      return sl;
    end else if (sel == FAST_SOURCE_STABLE_FLAG_SEL_FAST) begin
      return fl;
    end else begin
      return t[FAST_SOURCE_STABLE_FLAG_SEL_FAST - sel - 3'h1];
    end
  endfunction

  // ****************************************************************
  // Glitch-free switch
  // ****************************************************************
  fast_source_stable_flag_sw_state_t state_q, state_d;
  logic [2:0] target_q, target_d;
  logic [3:0] edge_cnt_q, edge_cnt_d;
  logic       cur_lvl_q, cur_lvl_d, new_lvl_q, new_lvl_d;
  logic       out_q, out_d;
  logic [31:0] stab_cnt_q, stab_cnt_d;
  logic       cur_lvl, new_lvl;

  assign cur_lvl = src_level(active_sel_q, taps, fast_sync_q[1],
                             slow_sync_q[1]);
  assign new_lvl = src_level(target_q, taps, fast_sync_q[1],
                             slow_sync_q[1]);

  always_comb begin
    state_d      = state_q;
    active_sel_d = active_sel_q;
    target_d     = freq_select_q;
    edge_cnt_d   = edge_cnt_q;
    cur_lvl_d    = cur_lvl;
    new_lvl_d    = new_lvl;
    out_d        = out_q;
    stable_d     = stable_q;
    stab_cnt_d   = stab_cnt_q;
    if (stab_cnt_q != '0) begin
      stab_cnt_d = stab_cnt_q - 32'h1;
      if (stab_cnt_q == 32'h1) begin
        stable_d = 1'b1;
      end
    end
    unique case (state_q)
      FAST_SOURCE_STABLE_FLAG_SW_RUN: begin
        out_d = cur_lvl;
        if (freq_select_q != active_sel_q) begin
          state_d = FAST_SOURCE_STABLE_FLAG_SW_LOW;
        end
      end
      FAST_SOURCE_STABLE_FLAG_SW_LOW: begin
        if (cur_lvl_q & ~cur_lvl) begin
          out_d      = 1'b0;
          edge_cnt_d = '0;
          state_d    = FAST_SOURCE_STABLE_FLAG_SW_WAIT;
        end else begin
          out_d = cur_lvl;
        end
      end
      FAST_SOURCE_STABLE_FLAG_SW_WAIT: begin
        out_d = 1'b0;
        if (target_q != freq_select_q) begin
          edge_cnt_d = '0; // Retarget restarts the count
          // Old target level must not fake a falling edge of the new one
          new_lvl_d  = 1'b0;
        end else if (new_lvl_q & ~new_lvl) begin
          edge_cnt_d = edge_cnt_q + 4'h1;
          if (edge_cnt_q == 4'(FAST_SOURCE_STABLE_FLAG_HANDOVER_EDGES - 1)) begin
            active_sel_d = target_q;
            state_d      = FAST_SOURCE_STABLE_FLAG_SW_RUN;
            if (sel_is_slow(active_sel_q) && !sel_is_slow(target_q)) begin
              stable_d   = 1'b0;
              stab_cnt_d = 32'(STAB_CYCLES);
            end else if (sel_is_slow(target_q)) begin
              stab_cnt_d = '0;
            end
            // Fast to fast leaves the flag as it is
          end
        end
      end
      default: begin
        state_d = FAST_SOURCE_STABLE_FLAG_SW_RUN;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      trim_q        <= FAST_SOURCE_STABLE_FLAG_TRIM_RST[5:0];
      freq_select_q <= FAST_SOURCE_STABLE_FLAG_CTRL_RST[FAST_SOURCE_STABLE_FLAG_SEL_MSB:FAST_SOURCE_STABLE_FLAG_SEL_LSB];
      pinmode_q     <= '0;
      rdata_q       <= '0;
      fast_sync_q   <= '0;
      slow_sync_q   <= '0;
      fast_prev_q   <= 1'b0;
      slow_prev_q   <= 1'b0;
      state_q       <= FAST_SOURCE_STABLE_FLAG_SW_RUN;
      active_sel_q  <= FAST_SOURCE_STABLE_FLAG_SEL_SLOW;
      target_q      <= FAST_SOURCE_STABLE_FLAG_SEL_SLOW;
      edge_cnt_q    <= '0;
      cur_lvl_q     <= 1'b0;
      new_lvl_q     <= 1'b0;
      out_q         <= 1'b0;
      stable_q      <= 1'b0;
      stab_cnt_q    <= '0;
    end else begin
      trim_q        <= trim_d;
      freq_select_q <= freq_select_d;
      pinmode_q     <= pinmode_d;
      rdata_q       <= rdata_d;
      fast_sync_q   <= {fast_sync_q[0], fast_tick};
      slow_sync_q   <= {slow_sync_q[0], slow_tick};
      fast_prev_q   <= fast_sync_q[1];
      slow_prev_q   <= slow_sync_q[1];
      state_q       <= state_d;
      active_sel_q  <= active_sel_d;
      target_q      <= target_d;
      edge_cnt_q    <= edge_cnt_d;
      cur_lvl_q     <= cur_lvl_d;
      new_lvl_q     <= new_lvl_d;
      out_q         <= out_d;
      stable_q      <= stable_d;
      stab_cnt_q    <= stab_cnt_d;
    end
  end

  // ****************************************************************
  // Outputs and pins
  // ****************************************************************
  // Fosc/4 is tap 1 of a divider on the routed clock output
  logic       out_prev_q;
  logic [1:0] quarter_q, quarter_d;

  always_comb begin
    quarter_d = quarter_q;
    if (out_q & ~out_prev_q) begin
      quarter_d = quarter_q + 2'h1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      out_prev_q <= 1'b0;
      quarter_q  <= '0;
    end else begin
      out_prev_q <= out_q;
      quarter_q  <= quarter_d;
    end
  end

  assign reg_rdata    = rdata_q;
  assign trim_value   = trim_q;
  assign clock_output = out_q;
  assign switch_busy  = state_q != FAST_SOURCE_STABLE_FLAG_SW_RUN;
  assign fast_osc_enable = !sel_is_slow(freq_select_q)
                         || !sel_is_slow(active_sel_q);
  // Slow source also clocks watchdog timing, so the WDT or PWT pin-mode bit keeps it enabled
  assign slow_osc_enable = sel_is_slow(freq_select_q)
                         || sel_is_slow(active_sel_q)
                         || pinmode_q[FAST_SOURCE_STABLE_FLAG_PM_WDT_BIT]
                         || pinmode_q[FAST_SOURCE_STABLE_FLAG_PM_PWT_BIT];

  assign first_osc_pin_out  = port_bit_seven_out;
  assign first_osc_pin_oe   = port_bit_seven_oe;
  assign port_bit_seven_in  = first_osc_pin_in;
  assign second_osc_pin_out = pinmode_q[FAST_SOURCE_STABLE_FLAG_PM_IO_BIT] ? port_bit_six_out
                            : quarter_q[1];
  assign second_osc_pin_oe  = pinmode_q[FAST_SOURCE_STABLE_FLAG_PM_IO_BIT] ? port_bit_six_oe
                            : 1'b1;
  assign port_bit_six_in    = pinmode_q[FAST_SOURCE_STABLE_FLAG_PM_IO_BIT] ? second_osc_pin_in
                            : 1'b0;
endmodule

// >>> design/fast_source_stable_flag_pkg.sv
package fast_source_stable_flag_pkg;

  // ****************************************************************
  // Register map (word index on the plain register port)
  // ****************************************************************
  localparam logic [1:0] FAST_SOURCE_STABLE_FLAG_ADDR_TRIM     = 2'h0;
  localparam logic [1:0] FAST_SOURCE_STABLE_FLAG_ADDR_CONTROL  = 2'h1;
  localparam logic [1:0] FAST_SOURCE_STABLE_FLAG_ADDR_PINMODE  = 2'h2;
  localparam logic [1:0] FAST_SOURCE_STABLE_FLAG_ADDR_STATUS   = 2'h3;

  // ****************************************************************
  // Field layout
  // ****************************************************************
  localparam int FAST_SOURCE_STABLE_FLAG_TRIM_MSB   = 5;
  localparam int FAST_SOURCE_STABLE_FLAG_SEL_MSB    = 6;
  localparam int FAST_SOURCE_STABLE_FLAG_SEL_LSB    = 4;
  localparam int FAST_SOURCE_STABLE_FLAG_STABLE_BIT = 2;
  localparam int FAST_SOURCE_STABLE_FLAG_PM_IO_BIT  = 0;
  localparam int FAST_SOURCE_STABLE_FLAG_PM_WDT_BIT = 1;
  localparam int FAST_SOURCE_STABLE_FLAG_PM_PWT_BIT = 2;
  localparam logic [7:0] FAST_SOURCE_STABLE_FLAG_TRIM_RST = 8'h00;
  localparam logic [7:0] FAST_SOURCE_STABLE_FLAG_CTRL_RST = 8'h00;

  // ****************************************************************
  // Frequency select encodings
  // ****************************************************************
  localparam logic [2:0] FAST_SOURCE_STABLE_FLAG_SEL_SLOW = 3'h0;
  localparam logic [2:0] FAST_SOURCE_STABLE_FLAG_SEL_FAST = 3'h7;
  localparam int FAST_SOURCE_STABLE_FLAG_HANDOVER_EDGES   = 8;

  // ****************************************************************
  // Timing (core clock 25 MHz)
  // ****************************************************************
  localparam int FAST_SOURCE_STABLE_FLAG_CLK_HZ        = 25000000;
  localparam int FAST_SOURCE_STABLE_FLAG_STAB_DELAY_US = 4000;
  localparam int FAST_SOURCE_STABLE_FLAG_STAB_CYCLES   =
    (FAST_SOURCE_STABLE_FLAG_CLK_HZ / 1000000) * FAST_SOURCE_STABLE_FLAG_STAB_DELAY_US;
  localparam int FAST_SOURCE_STABLE_FLAG_TRIM_FAST_US  = 1000;
  localparam int FAST_SOURCE_STABLE_FLAG_TRIM_SLOW_PERIODS = 8;

  typedef enum logic [1:0] {
    FAST_SOURCE_STABLE_FLAG_SW_RUN  = 2'b00,
    FAST_SOURCE_STABLE_FLAG_SW_LOW  = 2'b01,
    FAST_SOURCE_STABLE_FLAG_SW_WAIT = 2'b10
  } fast_source_stable_flag_sw_state_t;

endpackage

// >>> design/fast_source_stable_flag_clk_div.sv
`timescale 1ns/1ps
// Free running divider; tap n toggles at src/2^(n+1)
module fast_source_stable_flag_clk_div #(
  parameter int WIDTH = 6
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  // Source enable and taps
  input  wire logic             tick,
  output logic      [WIDTH-1:0] taps
);
  logic [WIDTH-1:0] cnt_q;
  logic [WIDTH-1:0] cnt_d;

  always_comb begin
    cnt_d = cnt_q;
    if (tick) begin
      cnt_d = cnt_q + WIDTH'(1);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign taps = cnt_q;
endmodule

// >>> dv/fast_source_stable_flag_osc_block_sva.sv
`timescale 1ns/1ps
module fast_source_stable_flag_osc_block_sva
  import fast_source_stable_flag_pkg::*;
(
  // Clock and reset
  input wire logic       core_clk,
  input wire logic       rst_n,
  // Register port
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_write,
  input wire logic       reg_read,
  input wire logic [7:0] reg_rdata,
  // Results
  input wire logic [5:0] trim_value,
  input wire logic       slow_osc_enable,
  input wire logic       clock_output,
  input wire logic       switch_busy,
  // Pins
  input wire logic       first_osc_pin_in,
  input wire logic       first_osc_pin_oe,
  input wire logic       second_osc_pin_in,
  input wire logic       second_osc_pin_oe,
  input wire logic       second_osc_pin_out,
  input wire logic       port_bit_six_oe,
  input wire logic       port_bit_six_in,
  input wire logic       port_bit_seven_oe,
  input wire logic       port_bit_seven_in
);
  // ****************************************************************
  // Shadows built from the port only, so a stuck design register shows
  // ****************************************************************
  logic [2:0] sel_q, sel_d, pm_q, pm_d;
  logic       co_q, held_q, held_d;

  always_comb begin
    sel_d = sel_q;
    pm_d = pm_q;
    if (reg_write && reg_addr == FAST_SOURCE_STABLE_FLAG_ADDR_CONTROL) begin
      sel_d = reg_wdata[6:4];
    end
    if (reg_write && reg_addr == FAST_SOURCE_STABLE_FLAG_ADDR_PINMODE) begin
      pm_d = reg_wdata[2:0];
    end
    held_d = switch_busy && (held_q || (co_q && !clock_output));
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sel_q <= 3'h0;
      pm_q <= 3'h0;
      held_q <= 1'b0;
    end else begin
      sel_q <= sel_d;
      pm_q <= pm_d;
      held_q <= held_d;
    end
    co_q <= clock_output;
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence s_sel_change;
    reg_write && reg_addr == FAST_SOURCE_STABLE_FLAG_ADDR_CONTROL && reg_wdata[6:4] != sel_q;
  endsequence
  sequence s_ctrl_read;
    reg_read && reg_addr == FAST_SOURCE_STABLE_FLAG_ADDR_CONTROL;
  endsequence

  AST_CTRL_RSVD: assert property (s_ctrl_read |=>
    reg_rdata[7] == 1'b0 && reg_rdata[3] == 1'b0 && reg_rdata[1:0] == 2'h0)
    else $error("reserved control bits not zero");
  AST_CTRL_SEL: assert property (s_ctrl_read |=>
    reg_rdata[6:4] == $past(sel_q)) else $error("select readback wrong");
  AST_TRIM_WRITE: assert property (
    reg_write && reg_addr == FAST_SOURCE_STABLE_FLAG_ADDR_TRIM
    |=> trim_value == $past(reg_wdata[5:0])) else $error("trim not taken");
  AST_TRIM_HOLD: assert property (
    !(reg_write && reg_addr == FAST_SOURCE_STABLE_FLAG_ADDR_TRIM) |=> $stable(trim_value))
    else $error("trim moved without write");
  AST_BUSY_START: assert property (s_sel_change |-> ##[1:3] switch_busy)
    else $error("switch did not start");
  AST_HOLD_LOW: assert property (held_q && switch_busy |-> !clock_output)
    else $error("clock output not held low");
  AST_CLKOUT_MODE: assert property (!pm_q[FAST_SOURCE_STABLE_FLAG_PM_IO_BIT] |->
    second_osc_pin_oe && first_osc_pin_oe == port_bit_seven_oe)
    else $error("clock-out pin mode wrong");
  AST_DUAL_MODE: assert property (pm_q[FAST_SOURCE_STABLE_FLAG_PM_IO_BIT] |->
    second_osc_pin_oe == port_bit_six_oe
    && port_bit_six_in == second_osc_pin_in)
    else $error("dual pin mode wrong");
  AST_SEVEN_IN: assert property (port_bit_seven_in == first_osc_pin_in)
    else $error("port bit seven input wrong");
  AST_SLOW_EN: assert property (
    pm_q[FAST_SOURCE_STABLE_FLAG_PM_WDT_BIT] || pm_q[FAST_SOURCE_STABLE_FLAG_PM_PWT_BIT] |-> slow_osc_enable)
    else $error("slow source off while needed");
  AST_QUARTER_STEP: assert property (
    !pm_q[FAST_SOURCE_STABLE_FLAG_PM_IO_BIT] && !$past(pm_q[FAST_SOURCE_STABLE_FLAG_PM_IO_BIT])
    && $changed(second_osc_pin_out)
    |-> $past(clock_output) && !$past(clock_output, 2))
    else $error("clock-out pin moved off a routed clock rise");
endmodule

bind fast_source_stable_flag_osc_block fast_source_stable_flag_osc_block_sva u_sva (
  .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
  .reg_rdata(reg_rdata), .trim_value(trim_value),
  .slow_osc_enable(slow_osc_enable), .clock_output(clock_output),
  .switch_busy(switch_busy), .first_osc_pin_in(first_osc_pin_in),
  .first_osc_pin_oe(first_osc_pin_oe), .second_osc_pin_in(second_osc_pin_in),
  .second_osc_pin_oe(second_osc_pin_oe),
  .second_osc_pin_out(second_osc_pin_out), .port_bit_six_oe(port_bit_six_oe),
  .port_bit_six_in(port_bit_six_in), .port_bit_seven_oe(port_bit_seven_oe),
  .port_bit_seven_in(port_bit_seven_in));

// >>> dv/fast_source_stable_flag_osc_block_bench.sv
`timescale 1ns/1ps
module fast_source_stable_flag_osc_block_bench;
  import fast_source_stable_flag_pkg::*;
  logic       core_clk, rst_n, fast_tick, slow_tick, reg_write, reg_read;
  logic [1:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic [5:0] trim_value;
  logic       fast_osc_enable, slow_osc_enable, clock_output, switch_busy;
  logic       first_osc_pin_in, first_osc_pin_out, first_osc_pin_oe;
  logic       second_osc_pin_in, second_osc_pin_out, second_osc_pin_oe;
  logic       port_bit_six_out, port_bit_six_oe, port_bit_six_in;
  logic       port_bit_seven_out, port_bit_seven_oe, port_bit_seven_in;
  logic       pin1_ext, pin2_ext;
  int         err_total, samples_checked, tick_cnt;

  // Pin levels resolved from both drivers
  assign first_osc_pin_in = first_osc_pin_oe ? first_osc_pin_out : pin1_ext;
  assign second_osc_pin_in = second_osc_pin_oe ? second_osc_pin_out : pin2_ext;

  // Short stabilisation count keeps the run brief
  fast_source_stable_flag_osc_block #(.STAB_CYCLES(50)) dut (
    .core_clk(core_clk), .rst_n(rst_n), .fast_tick(fast_tick),
    .slow_tick(slow_tick), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .trim_value(trim_value), .fast_osc_enable(fast_osc_enable),
    .slow_osc_enable(slow_osc_enable), .clock_output(clock_output),
    .switch_busy(switch_busy), .first_osc_pin_in(first_osc_pin_in),
    .first_osc_pin_out(first_osc_pin_out), .first_osc_pin_oe(first_osc_pin_oe),
    .second_osc_pin_in(second_osc_pin_in),
    .second_osc_pin_out(second_osc_pin_out),
    .second_osc_pin_oe(second_osc_pin_oe),
    .port_bit_six_out(port_bit_six_out), .port_bit_six_oe(port_bit_six_oe),
    .port_bit_six_in(port_bit_six_in), .port_bit_seven_out(port_bit_seven_out),
    .port_bit_seven_oe(port_bit_seven_oe),
    .port_bit_seven_in(port_bit_seven_in));

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // Oscillator cells well below a quarter of the core rate
  always @(posedge core_clk) begin
    tick_cnt <= tick_cnt + 1;
    if (tick_cnt % 3 == 0) begin
      fast_tick <= ~fast_tick;
    end
    if (tick_cnt % 8 == 0) begin
      slow_tick <= ~slow_tick;
    end
  end

  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge core_clk);
    reg_write <= 1'b0;
  endtask

  task automatic rd(input logic [1:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge core_clk);
    reg_read <= 1'b0;
    @(negedge core_clk);
    chk("reg_rdata", exp, reg_rdata);
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    repeat (4) @(posedge core_clk);
    while (switch_busy !== 1'b0 && n < 4000) begin
      @(negedge core_clk);
      n++;
    end
    chk("switch_busy", 8'h00, {7'h00, switch_busy});
  endtask

  // Fosc/4 on the second pin: four routed clock rises per pin rise
  task automatic chk_quarter();
    int   rises;
    int   n;
    int   seen;
    logic co_prev;
    logic pin_prev;
    rises = 0;
    n = 0;
    seen = 0;
    co_prev = clock_output;
    pin_prev = second_osc_pin_out;
    while (seen < 2 && n < 200) begin
      @(negedge core_clk);
      n++;
      if (seen == 1 && clock_output && !co_prev) begin
        rises++;
      end
      if (second_osc_pin_out && !pin_prev) begin
        seen++;
      end
      co_prev = clock_output;
      pin_prev = second_osc_pin_out;
    end
    chk("quarter_rises", 8'h04, 8'(rises));
  endtask

  // Software-style wait for the stable flag after leaving the slow source
  task automatic poll_stable(input logic [7:0] exp);
    int n;
    n = 0;
    do begin
      @(posedge core_clk);
      reg_addr <= FAST_SOURCE_STABLE_FLAG_ADDR_CONTROL;
      reg_read <= 1'b1;
      @(posedge core_clk);
      reg_read <= 1'b0;
      @(negedge core_clk);
      n++;
    end while (reg_rdata[FAST_SOURCE_STABLE_FLAG_STABLE_BIT] !== 1'b1 && n < 200);
    chk("stable_poll", exp, reg_rdata);
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Watchdog well beyond the few thousand cycles the sequence needs
  initial begin
    repeat (20000) @(posedge core_clk);
    err_total++;
    conclude();
  end

  initial begin
    {rst_n, fast_tick, slow_tick, reg_write, reg_read} = 5'h00;
    reg_addr = 2'h0;
    reg_wdata = 8'h00;
    {port_bit_six_out, port_bit_six_oe, port_bit_seven_out} = 3'h0;
    {port_bit_seven_oe, pin1_ext, pin2_ext} = 3'h7;
    err_total = 0;
    samples_checked = 0;
    tick_cnt = 0;
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(FAST_SOURCE_STABLE_FLAG_ADDR_TRIM, 8'h00);
    rd(FAST_SOURCE_STABLE_FLAG_ADDR_CONTROL, 8'h00);
    chk("fast_osc_enable", 8'h00, {7'h00, fast_osc_enable});
    chk("slow_osc_enable", 8'h01, {7'h00, slow_osc_enable});
    wr(FAST_SOURCE_STABLE_FLAG_ADDR_TRIM, 8'hFF);
    rd(FAST_SOURCE_STABLE_FLAG_ADDR_TRIM, 8'h3F);
    chk("trim_value", 8'h3F, {2'h0, trim_value});
    wr(FAST_SOURCE_STABLE_FLAG_ADDR_STATUS, 8'hFF);
    rd(FAST_SOURCE_STABLE_FLAG_ADDR_STATUS, 8'h00);
    chk("second_osc_pin_oe", 8'h01, {7'h00, second_osc_pin_oe});
    chk("port_bit_seven_in", 8'h00, {7'h00, port_bit_seven_in});
    wr(FAST_SOURCE_STABLE_FLAG_ADDR_PINMODE, 8'h01);
    @(negedge core_clk);
    chk("second_osc_pin_oe", 8'h00, {7'h00, second_osc_pin_oe});
    chk("port_bit_six_in", 8'h01, {7'h00, port_bit_six_in});
    wr(FAST_SOURCE_STABLE_FLAG_ADDR_PINMODE, 8'h00);
    wr(FAST_SOURCE_STABLE_FLAG_ADDR_CONTROL, 8'h70);
    rd(FAST_SOURCE_STABLE_FLAG_ADDR_CONTROL, 8'h70);
    wait_idle();
    rd(FAST_SOURCE_STABLE_FLAG_ADDR_STATUS, 8'h70);
    rd(FAST_SOURCE_STABLE_FLAG_ADDR_CONTROL, 8'h70);
    chk("fast_osc_enable", 8'h01, {7'h00, fast_osc_enable});
    chk("slow_osc_enable", 8'h00, {7'h00, slow_osc_enable});
    chk_quarter();
    wr(FAST_SOURCE_STABLE_FLAG_ADDR_PINMODE, 8'h02);
    @(negedge core_clk);
    chk("slow_osc_enable", 8'h01, {7'h00, slow_osc_enable});
    wr(FAST_SOURCE_STABLE_FLAG_ADDR_PINMODE, 8'h04);
    @(negedge core_clk);
    chk("slow_osc_enable", 8'h01, {7'h00, slow_osc_enable});
    wr(FAST_SOURCE_STABLE_FLAG_ADDR_PINMODE, 8'h00);
    repeat (60) @(posedge core_clk);
    rd(FAST_SOURCE_STABLE_FLAG_ADDR_CONTROL, 8'h74);
    for (int s = 6; s >= 0; s--) begin
      wr(FAST_SOURCE_STABLE_FLAG_ADDR_CONTROL, {1'b0, s[2:0], 4'h0});
      wait_idle();
      rd(FAST_SOURCE_STABLE_FLAG_ADDR_STATUS, {1'b0, s[2:0], 4'h0});
      rd(FAST_SOURCE_STABLE_FLAG_ADDR_CONTROL, {1'b0, s[2:0], 4'h4});
    end
    // Retarget while the first handover still waits for the slow clock to fall
    wr(FAST_SOURCE_STABLE_FLAG_ADDR_CONTROL, 8'h70);
    wr(FAST_SOURCE_STABLE_FLAG_ADDR_CONTROL, 8'h20);
    wait_idle();
    rd(FAST_SOURCE_STABLE_FLAG_ADDR_STATUS, 8'h20);
    rd(FAST_SOURCE_STABLE_FLAG_ADDR_CONTROL, 8'h20);
    poll_stable(8'h24);
    @(posedge core_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(FAST_SOURCE_STABLE_FLAG_ADDR_CONTROL, 8'h00);
    rd(FAST_SOURCE_STABLE_FLAG_ADDR_TRIM, 8'h00);
    conclude();
  end
endmodule
